// [src/timer3_core.sv]
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "timer3_regs.svh"

// Summary of operation
// - Wide mode moves all 16 count bits at once; otherwise two byte accesses.
// - Capture-source high bit set: this timer feeds both compare units.
// - Capture-source 01: this timer feeds enhanced unit, other one standard.
// - Capture-source 00: other timer feeds both compare units.
// - Prescaler divides selected clock by 1, 2, 4 or 8.
// - External clock unsynchronised when sync-disable set, else aligned.
// - Internal clock selected: sync-disable ignored, count instruction clock.
// - Wrap from all-ones to zero sets the overflow flag.
// - Trigger from a compare unit using this timer clears the count.
// - After reset the timer is disabled and not running.
module timer3_core (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // External clock pins
  input  wire logic        osc_pin,
  input  wire logic        external_clock_pin,
  input  wire logic        timer_osc_enable,
  // Compare/capture units
  input  wire logic        std_trigger,
  input  wire logic        enh_trigger,
  output timer3_pkg::timebase_t timebase,
  output logic [15:0]      count_value,
  // Interrupt
  output logic             irq
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  timer3_pkg::ctrl_t ctrl;
  logic [15:0]       count;
  logic              ovf_status;
  logic              ovf_mask;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic [1:0]        insn_div;
  logic              osc_s1;
  logic              osc_s2;
  logic              pin_s1;
  logic              pin_s2;
  logic              ext_prev;
  logic              ext_armed;
  logic              ext_pend;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        aw_fire  = awvalid && awready;
  wire        w_fire   = wvalid && wready;
  wire        ar_fire  = arvalid && arready;
  wire        wr_do    = aw_held && w_held && !bvalid;
  wire        wr_ctrl  = wr_do && aw_addr_q == `T3_CTRL_OFS;
  wire        wr_lo    = wr_do && aw_addr_q == `T3_COUNT_LO_OFS;
  wire        wr_hi    = wr_do && aw_addr_q == `T3_COUNT_HI_OFS;
  wire        wr_stat  = wr_do && aw_addr_q == `T3_STATUS_OFS;
  wire        wr_mask  = wr_do && aw_addr_q == `T3_MASK_OFS;
  wire        wr_hit   = wr_ctrl || wr_lo || wr_hi || wr_stat || wr_mask;
  wire        lane_lo  = wstrb_q[`T3_LANE_LO];
  wire        lane_hi  = wstrb_q[`T3_LANE_HI];
  wire        wide     = ctrl.wide_access_mode;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  // ****************************************************************
  // Count write path
  // ****************************************************************
  // Wide mode: the low-byte address carries both bytes in one access,
  // so software never sees a torn value between two byte writes.
  wire [15:0] wr_value;
  wire        cnt_write;
  assign wr_value[`T3_BYTE_LO] =
    (wr_lo && lane_lo) ? wdata_q[`T3_BYTE_LO] : count[`T3_BYTE_LO];
  assign wr_value[`T3_BYTE_HI] =
    (wr_lo && wide && lane_hi) ? wdata_q[`T3_BYTE_HI] :
    (wr_hi && !wide && lane_lo) ? wdata_q[`T3_BYTE_LO] :
    count[`T3_BYTE_HI];
  assign cnt_write = (wr_lo && (lane_lo || (wide && lane_hi))) ||
                     (wr_hi && !wide && lane_lo);

  // ****************************************************************
  // Read decode
  // ****************************************************************
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  wire [31:0] rd_lo   = wide ? {16'h0000, count} :
                        byte_word(count[`T3_BYTE_LO]);
  wire [31:0] rd_hi   = wide ? 32'h00000000 :
                        byte_word(count[`T3_BYTE_HI]);
  wire        rd_ctl  = araddr == `T3_CTRL_OFS;
  wire        rd_cl   = araddr == `T3_COUNT_LO_OFS;
  wire        rd_ch   = araddr == `T3_COUNT_HI_OFS;
  wire        rd_st   = araddr == `T3_STATUS_OFS;
  wire        rd_mk   = araddr == `T3_MASK_OFS;
  wire        rd_hit  = rd_ctl || rd_cl || rd_ch || rd_st || rd_mk;
  wire [31:0] rd_mux  = rd_ctl ? byte_word(ctrl) :
                        rd_cl  ? rd_lo :
                        rd_ch  ? rd_hi :
                        rd_st  ? {31'h00000000, ovf_status} :
                        rd_mk  ? {31'h00000000, ovf_mask} :
                        32'h00000000;

  // ****************************************************************
  // AXI4-Lite handshake
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= `T3_CTRL_OFS;
    end else if (aw_fire) begin
      aw_held   <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_do) begin
      aw_held   <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (w_fire) begin
      w_held  <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_do) begin
      w_held  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `T3_RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `T3_RESP_OKAY : `T3_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `T3_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? `T3_RESP_OKAY : `T3_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `T3_CTRL_RST;
    end else if (wr_ctrl && lane_lo) begin
      ctrl <= wdata_q[`T3_BYTE_LO];
    end
  end

  assign timebase.std_uses_this = ctrl.capture_source_high;
  assign timebase.enh_uses_this = ctrl.capture_source_high ||
                                  ctrl.capture_source_low;

  // ****************************************************************
  // Clock sources
  // ****************************************************************
  // Instruction clock is a quarter of the bus clock.
  wire insn_tick = insn_div == `T3_INSN_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn_div <= 2'h0;
    end else begin
      insn_div <= insn_div + 2'h1;
    end
  end

  // Pins always pass two flops; the "unsynchronised" mode only skips
  // the extra alignment to the instruction clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      osc_s1 <= osc_pin;
      osc_s2 <= osc_s1;
      pin_s1 <= external_clock_pin;
      pin_s2 <= pin_s1;
    end
  end

  wire ext_on    = ctrl.clock_source_select && ctrl.counter_run;
  wire ext_level = timer_osc_enable ? osc_s2 : pin_s2;
  wire ext_rise  = ext_on && ext_armed && ext_level && !ext_prev;
  wire sync_on   = !ctrl.ext_sync_disable;

  always_ff @(posedge aclk) begin
    if (!aresetn || !ext_on) begin
      ext_prev  <= 1'b1;
      ext_armed <= 1'b0;
    end else begin
      ext_prev  <= ext_level;
      ext_armed <= ext_armed || !ext_level;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ext_on || !sync_on || insn_tick) begin
      ext_pend <= 1'b0;
    end else if (ext_rise) begin
      ext_pend <= 1'b1;
    end
  end

  wire ext_tick = sync_on ? insn_tick && (ext_pend || ext_rise) :
                  ext_rise;
  wire raw_tick = ctrl.clock_source_select ? ext_tick :
                  insn_tick;

  // ****************************************************************
  // Prescaler and counter
  // ****************************************************************
  logic count_tick;
  wire  ps_clear = !ctrl.counter_run || cnt_write || wr_ctrl;

  timer3_prescaler u_prescaler (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .clear           (ps_clear),
    .prescale_select (ctrl.prescale_select),
    .tick_in         (raw_tick && ctrl.counter_run),
    .tick_out        (count_tick)
  );

  wire trig_clear = (std_trigger && timebase.std_uses_this) ||
                    (enh_trigger && timebase.enh_uses_this);
  wire ovf_event  = count_tick && !cnt_write && !trig_clear &&
                    count == `T3_COUNT_MAX;

  // Software write beats a trigger, a trigger beats counting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `T3_COUNT_RST;
    end else if (cnt_write) begin
      count <= wr_value;
    end else if (trig_clear) begin
      count <= `T3_COUNT_RST;
    end else if (count_tick) begin
      count <= count + 16'h0001;
    end
  end

  assign count_value = count;

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // A wrap in the same cycle as the clearing write stays set.
  wire next_status = (ovf_status &&
                      !(wr_stat && lane_lo && wdata_q[`T3_OVF_BIT])) ||
                     ovf_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_status <= 1'b0;
      ovf_mask   <= 1'b0;
      irq        <= 1'b0;
    end else begin
      ovf_status <= next_status;
      if (wr_mask && lane_lo) begin
        ovf_mask <= wdata_q[`T3_OVF_BIT];
      end
      irq <= ovf_status && ovf_mask;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_wide_read;
    @(posedge aclk) disable iff (!aresetn)
    (ar_fire && rd_cl && wide) |=> rdata[15:0] == $past(count);
  endproperty
  a_wide_read: assert property (p_wide_read)
    else $error("wide read did not return all 16 count bits");

  property p_both_this;
    @(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && lane_lo && wdata_q[6]) |=>
      timebase.std_uses_this && timebase.enh_uses_this;
  endproperty
  a_both_this: assert property (p_both_this)
    else $error("high capture-source bit did not select this timer");

  property p_enh_only;
    @(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && lane_lo && !wdata_q[6] && wdata_q[3]) |=>
      !timebase.std_uses_this && timebase.enh_uses_this;
  endproperty
  a_enh_only: assert property (p_enh_only)
    else $error("capture-source 01 routed wrongly");

  property p_none_this;
    @(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && lane_lo && !wdata_q[6] && !wdata_q[3]) |=>
      !timebase.std_uses_this && !timebase.enh_uses_this;
  endproperty
  a_none_this: assert property (p_none_this)
    else $error("capture-source 00 routed wrongly");

  property p_sync_align;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl.clock_source_select && sync_on && raw_tick) |-> insn_tick;
  endproperty
  a_sync_align: assert property (p_sync_align)
    else $error("synchronised external tick off the instruction clock");

  property p_int_clock;
    @(posedge aclk) disable iff (!aresetn)
    (!ctrl.clock_source_select) |-> (raw_tick == insn_tick);
  endproperty
  a_int_clock: assert property (p_int_clock)
    else $error("internal clock not used");

  property p_first_fall;
    @(posedge aclk) disable iff (!aresetn)
    (ctrl.clock_source_select && raw_tick) |-> ext_armed;
  endproperty
  a_first_fall: assert property (p_first_fall)
    else $error("external edge counted before a falling edge");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    (!ctrl.counter_run && !cnt_write && !trig_clear) |=>
      count == $past(count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while stopped");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    ovf_event |=> (ovf_status && count == `T3_COUNT_RST);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not set overflow flag");

  property p_trig;
    @(posedge aclk) disable iff (!aresetn)
    (trig_clear && !cnt_write) |=> count == `T3_COUNT_RST;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not clear the count");

  property p_reset_off;
    @(posedge aclk)
    (!aresetn) |=> (!ctrl.counter_run && count == `T3_COUNT_RST);
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("timer running after reset");

  c_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
    ovf_event);
  c_trig: cover property (@(posedge aclk) disable iff (!aresetn)
    trig_clear && ctrl.counter_run);
  c_ext: cover property (@(posedge aclk) disable iff (!aresetn)
    ctrl.clock_source_select && count_tick);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq));

endmodule

// [inc/timer3_regs.svh]
`ifndef TIMER3_REGS_SVH
`define TIMER3_REGS_SVH

// ****************************************************************
// Register map (byte addresses on the AXI4-Lite bus)
// ****************************************************************
`define T3_ADDR_W       8
`define T3_CTRL_OFS     8'h00
`define T3_COUNT_LO_OFS 8'h04
`define T3_COUNT_HI_OFS 8'h08
`define T3_STATUS_OFS   8'h0c
`define T3_MASK_OFS     8'h10

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define T3_CTRL_RST     8'h00
`define T3_COUNT_RST    16'h0000
`define T3_COUNT_MAX    16'hffff
`define T3_OVF_BIT      0
`define T3_BYTE_LO      7:0
`define T3_BYTE_HI      15:8
`define T3_LANE_LO      0
`define T3_LANE_HI      1

// ****************************************************************
// Clocking and prescaler
// ****************************************************************
`define T3_INSN_LAST    2'h3
`define T3_PS_1         2'h0
`define T3_PS_2         2'h1
`define T3_PS_4         2'h2
`define T3_PS_8         2'h3
`define T3_PS_LIM_1     3'h0
`define T3_PS_LIM_2     3'h1
`define T3_PS_LIM_4     3'h3
`define T3_PS_LIM_8     3'h7

// ****************************************************************
// Bus responses
// ****************************************************************
`define T3_RESP_OKAY    2'h0
`define T3_RESP_SLVERR  2'h2

`endif

// [inc/timer3_pkg.sv]
package timer3_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       wide_access_mode;
    logic       capture_source_high;
    logic [1:0] prescale_select;
    logic       capture_source_low;
    logic       ext_sync_disable;
    logic       clock_source_select;
    logic       counter_run;
  } ctrl_t;

  // Time-base selection handed to the compare/capture units
  typedef struct packed {
    logic std_uses_this;
    logic enh_uses_this;
  } timebase_t;

endpackage

// [src/timer3_prescaler.sv]
`timescale 1ns/1ns
`include "timer3_regs.svh"

module timer3_prescaler (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] prescale_select,
  // Ticks
  input  wire logic       tick_in,
  output logic            tick_out
);

  logic [2:0] cnt;
  wire  [2:0] limit;

  function automatic logic [2:0] ps_limit(input logic [1:0] sel);
    case (sel)
      `T3_PS_2: ps_limit = `T3_PS_LIM_2;
      `T3_PS_4: ps_limit = `T3_PS_LIM_4;
      `T3_PS_8: ps_limit = `T3_PS_LIM_8;
      default:  ps_limit = `T3_PS_LIM_1;
    endcase
  endfunction

  assign limit    = ps_limit(prescale_select);
  assign tick_out = tick_in && !clear && (cnt == limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || (tick_in && cnt == limit)) begin
      cnt <= `T3_PS_LIM_1;
    end else if (tick_in) begin
      cnt <= cnt + 3'h1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ps_pass;
    @(posedge aclk) disable iff (!aresetn)
    (prescale_select == `T3_PS_1 && tick_in && !clear) |-> tick_out;
  endproperty
  a_ps_pass: assert property (p_ps_pass)
    else $error("prescaler 1:1 dropped a tick");

  property p_ps_div8;
    @(posedge aclk) disable iff (!aresetn)
    (prescale_select == `T3_PS_8 && tick_out) |-> cnt == `T3_PS_LIM_8;
  endproperty
  a_ps_div8: assert property (p_ps_div8)
    else $error("prescaler 1:8 fired early");

endmodule

// [verification/timer3_far_side.sv]
`timescale 1ns/1ns

module timer3_far_side (
  // Clock
  input  wire logic aclk,
  // Clock sources
  output logic      osc_pin,
  output logic      external_clock_pin,
  output logic      timer_osc_enable,
  // Compare unit triggers
  output logic      std_trigger,
  output logic      enh_trigger
);
  // Pins idle high, so every pulse opens with a falling edge
  initial begin
    osc_pin = 1'b1;
    external_clock_pin = 1'b1;
    timer_osc_enable = 1'b0;
    std_trigger = 1'b0;
    enh_trigger = 1'b0;
  end

  // Half period of six cycles outlasts the instruction tick, so the
  // synchronised path cannot drop an edge
  task automatic pulses(input logic en, input logic use_osc, input int n);
    timer_osc_enable <= en;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      if (use_osc) osc_pin <= 1'b0;
      else external_clock_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      if (use_osc) osc_pin <= 1'b1;
      else external_clock_pin <= 1'b1;
      repeat (6) @(posedge aclk);
    end
  endtask

  // One-cycle trigger pulses from the compare units
  task automatic fire(input logic s, input logic e);
    std_trigger <= s;
    enh_trigger <= e;
    @(posedge aclk);
    std_trigger <= 1'b0;
    enh_trigger <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

// [verification/tb_timer3_control_counter.sv]
`timescale 1ns/1ns
`include "timer3_regs.svh"

module tb_timer3_control_counter;
  logic                  aclk, aresetn, irq;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata, d, d0;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic                  osc_pin, external_clock_pin, timer_osc_enable;
  logic                  std_trigger, enh_trigger;
  logic [15:0]           count_value;
  timer3_pkg::timebase_t timebase;
  int                    errors, n_compared, cycles;

  timer3_core dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .osc_pin(osc_pin), .external_clock_pin(external_clock_pin),
    .timer_osc_enable(timer_osc_enable), .std_trigger(std_trigger),
    .enh_trigger(enh_trigger), .timebase(timebase),
    .count_value(count_value), .irq(irq)
  );

  // The bench clock never comes from the oscillator pin
  timer3_far_side far (
    .aclk(aclk), .osc_pin(osc_pin), .external_clock_pin(external_clock_pin),
    .timer_osc_enable(timer_osc_enable), .std_trigger(std_trigger),
    .enh_trigger(enh_trigger)
  );

  always #25 aclk = ~aclk;

  // ****************************************************************
  // Compare and report
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_range(input logic [31:0] got, lo, hi);
    n_compared++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Ports read at the falling edge, where they are settled
  task automatic peek(input int which, input logic [31:0] exp);
    logic [31:0] got;
    @(negedge aclk);
    got = (which == 0) ? {16'h0, count_value} :
          (which == 1) ? {31'h0, irq} : {30'h0, timebase};
    check(got, exp);
    @(posedge aclk);
  endtask

  task automatic summarize();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // AXI4-Lite master; handshakes sampled at the falling edge
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                    input logic [3:0] s, input logic [1:0] er);
    logic ad, wd, ah, wh, bh;
    logic [1:0] r;
    ad = 1'b0;
    wd = 1'b0;
    bh = 1'b0;
    awaddr <= a;
    wdata <= dt;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      ad = ad | ah;
      wd = wd | wh;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] dt);
    logic ah, rh;
    logic [1:0] r;
    ah = 1'b0;
    rh = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!ah) begin
      @(negedge aclk);
      ah = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      rh = rvalid;
      r = rresp;
      dt = rdata;
      @(posedge aclk);
    end
    rready <= 1'b0;
    check({30'h0, r}, {30'h0, er});
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`T3_CTRL_OFS, `T3_RESP_OKAY, d);
    check(d, 32'h00);
    repeat (40) @(posedge aclk);
    peek(0, 32'h0000);
    rd(8'h40, `T3_RESP_SLVERR, d);
    wr(8'h40, 32'h1, 4'hf, `T3_RESP_SLVERR);
    // Time-base routing and trigger clearing for every source code
    for (int c = 0; c < 4; c++) begin
      wr(`T3_CTRL_OFS, {24'h0, 1'b1, c[1], 2'b00, c[0], 3'b000}, 4'hf,
         `T3_RESP_OKAY);
      peek(2, {30'h0, c[1], c[1] | c[0]});
      wr(`T3_COUNT_LO_OFS, 32'h0100, 4'hf, `T3_RESP_OKAY);
      far.fire(1'b1, 1'b0);
      peek(0, c[1] ? 32'h0 : 32'h0100);
      wr(`T3_COUNT_LO_OFS, 32'h0100, 4'hf, `T3_RESP_OKAY);
      far.fire(1'b0, 1'b1);
      peek(0, (c[1] | c[0]) ? 32'h0 : 32'h0100);
    end
    // Six prescaled counts at each division; sync bit set once
    for (int p = 0; p < 4; p++) begin
      d0 = 32'h80 | (32'(p) << 4);
      wr(`T3_CTRL_OFS, d0, 4'hf, `T3_RESP_OKAY);
      wr(`T3_COUNT_LO_OFS, 32'h0, 4'hf, `T3_RESP_OKAY);
      wr(`T3_CTRL_OFS, d0 | ((p == 3) ? 32'h5 : 32'h1), 4'hf,
         `T3_RESP_OKAY);
      repeat (24 << p) @(posedge aclk);
      wr(`T3_CTRL_OFS, d0, 4'hf, `T3_RESP_OKAY);
      rd(`T3_COUNT_LO_OFS, `T3_RESP_OKAY, d);
      check_range(d, 32'd6, 32'd8);
      repeat (40) @(posedge aclk);
      peek(0, d);
    end
    // Single wide access, then two byte accesses
    wr(`T3_COUNT_LO_OFS, 32'h1234, 4'hf, `T3_RESP_OKAY);
    wr(`T3_COUNT_HI_OFS, 32'h55, 4'hf, `T3_RESP_OKAY);
    rd(`T3_COUNT_LO_OFS, `T3_RESP_OKAY, d);
    check(d, 32'h1234);
    rd(`T3_COUNT_HI_OFS, `T3_RESP_OKAY, d);
    check(d, 32'h0);
    wr(`T3_CTRL_OFS, 32'h00, 4'hf, `T3_RESP_OKAY);
    wr(`T3_COUNT_LO_OFS, 32'h56, 4'h1, `T3_RESP_OKAY);
    wr(`T3_COUNT_HI_OFS, 32'h78, 4'h1, `T3_RESP_OKAY);
    rd(`T3_COUNT_HI_OFS, `T3_RESP_OKAY, d);
    check(d, 32'h78);
    peek(0, 32'h7856);
    // Wrap sets the sticky flag; mask gates the interrupt
    wr(`T3_CTRL_OFS, 32'h80, 4'hf, `T3_RESP_OKAY);
    wr(`T3_COUNT_LO_OFS, 32'hfffe, 4'hf, `T3_RESP_OKAY);
    wr(`T3_MASK_OFS, 32'h1, 4'hf, `T3_RESP_OKAY);
    wr(`T3_CTRL_OFS, 32'h81, 4'hf, `T3_RESP_OKAY);
    repeat (20) @(posedge aclk);
    wr(`T3_CTRL_OFS, 32'h80, 4'hf, `T3_RESP_OKAY);
    rd(`T3_COUNT_LO_OFS, `T3_RESP_OKAY, d);
    check_range(d, 32'd1, 32'd8);
    rd(`T3_STATUS_OFS, `T3_RESP_OKAY, d);
    check(d, 32'h1);
    peek(1, 32'h1);
    wr(`T3_MASK_OFS, 32'h0, 4'hf, `T3_RESP_OKAY);
    repeat (2) @(posedge aclk);
    peek(1, 32'h0);
    wr(`T3_MASK_OFS, 32'h1, 4'hf, `T3_RESP_OKAY);
    wr(`T3_STATUS_OFS, 32'h1, 4'hf, `T3_RESP_OKAY);
    repeat (2) @(posedge aclk);
    rd(`T3_STATUS_OFS, `T3_RESP_OKAY, d);
    check(d, 32'h0);
    peek(1, 32'h0);
    // External pin unsynchronised, oscillator synchronised, wrong pin
    for (int e = 0; e < 3; e++) begin
      d0 = (e == 1) ? 32'h82 : 32'h86;
      wr(`T3_CTRL_OFS, d0, 4'hf, `T3_RESP_OKAY);
      wr(`T3_COUNT_LO_OFS, 32'h0, 4'hf, `T3_RESP_OKAY);
      wr(`T3_CTRL_OFS, d0 | 32'h1, 4'hf, `T3_RESP_OKAY);
      far.pulses(e != 0, e == 1, 5);
      wr(`T3_CTRL_OFS, d0, 4'hf, `T3_RESP_OKAY);
      rd(`T3_COUNT_LO_OFS, `T3_RESP_OKAY, d);
      check(d, (e == 2) ? 32'h0 : 32'h5);
    end
    summarize();
  end
endmodule
